// file: common/csw_map.svh
// How it works
// RULE1 - controller sends address byte before any data
// RULE2 - target acknowledges own address by pulling SDA
// RULE3 - write carries exactly two data bytes
// RULE4 - write changes only the selected switch
// RULE5 - any X line status can be read back
// RULE6 - readback select uses a write transaction
// RULE7 - select write: readback code, then dont-care byte
// RULE8 - select write captures eight switch states
// RULE9 - status fetch uses a read transaction
// RULE10 - read returns two bytes, first all zeros
// RULE11 - second byte: one bit per Y, 1=on
// RULE12 - readback codes decode to X0 through X7
// RULE13 - data byte: value, four X bits, three Y bits
// RULE14 - reserved X code changes no switch
`ifndef CSW_MAP_SVH
`define CSW_MAP_SVH
`define CSW_DEV_ADDR   7'h70
`define CSW_VAL_BIT    7
`define CSW_RB_X0      8'h34
`define CSW_RB_X1      8'h3c
`define CSW_RB_X2      8'h74
`define CSW_RB_X3      8'h7c
`define CSW_RB_X4      8'h35
`define CSW_RB_X5      8'h3d
`define CSW_RB_X6      8'h75
`define CSW_RB_X7      8'h7d
`define CSW_SCL_HALF   8'h04
`endif

// file: common/csw_pkg.sv
package csw_pkg;
  typedef enum logic [3:0] {
    CSW_T_IDLE  = 4'h0,
    CSW_T_ADDR  = 4'h1,
    CSW_T_AACK  = 4'h2,
    CSW_T_RX    = 4'h3,
    CSW_T_RACK  = 4'h4,
    CSW_T_TX    = 4'h5,
    CSW_T_TACK  = 4'h6,
    CSW_T_WAIT  = 4'h7
  } csw_tgt_st_t;
  typedef enum logic [3:0] {
    CSW_C_IDLE  = 4'h0,
    CSW_C_START = 4'h1,
    CSW_C_BIT   = 4'h2,
    CSW_C_ACK   = 4'h3,
    CSW_C_STOP  = 4'h4,
    CSW_C_DONE  = 4'h5
  } csw_ctl_st_t;
endpackage

// file: common/csw_if.sv
`timescale 1ns/1ps
interface csw_if;
  logic scl_o;
  logic scl_oe;
  logic sda_c_o;
  logic sda_c_oe;
  logic sda_t_o;
  logic sda_t_oe;
  wire  scl_i = ~(scl_oe & ~scl_o);
  wire  sda_i = ~((sda_c_oe & ~sda_c_o) | (sda_t_oe & ~sda_t_o));
  modport target (input scl_i, input sda_i, output sda_t_o, output sda_t_oe);
  modport ctrl   (input scl_i, input sda_i, output scl_o, output scl_oe, output sda_c_o, output sda_c_oe);
endinterface

// file: design/csw_target.sv
`timescale 1ns/1ps
`include "csw_map.svh"
module csw_target (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // bus
  csw_if.target            bus,
  // switch array, bit 8*x+y
  output      logic [63:0] switch_state
);
  function automatic logic [3:0] rb_decode(input logic [7:0] c); // [RULE12]
    unique case (c)
      `CSW_RB_X0: rb_decode = 4'h8;
      `CSW_RB_X1: rb_decode = 4'h9;
      `CSW_RB_X2: rb_decode = 4'ha;
      `CSW_RB_X3: rb_decode = 4'hb;
      `CSW_RB_X4: rb_decode = 4'hc;
      `CSW_RB_X5: rb_decode = 4'hd;
      `CSW_RB_X6: rb_decode = 4'he;
      `CSW_RB_X7: rb_decode = 4'hf;
      default:    rb_decode = 4'h0;
    endcase
  endfunction
  function automatic logic [3:0] x_decode(input logic [3:0] x); // [RULE13]
    if (x <= 4'h5) x_decode = {1'b1, x[2:0]};
    else if (x == 4'h8) x_decode = 4'he;
    else if (x == 4'h9) x_decode = 4'hf;
    else x_decode = 4'h0;
  endfunction

  logic [1:0] scl_s, sda_s;
  logic       scl_d, sda_d;
  csw_pkg::csw_tgt_st_t st, next_st;
  logic [7:0]  sh, next_sh;
  logic [2:0]  cnt, next_cnt;
  logic        byte2, next_byte2;
  logic        rd, next_rd;
  logic [7:0]  first, next_first;
  logic [7:0]  hold, next_hold;
  logic [63:0] next_switch_state;
  logic        sda_oe, next_sda_oe;
  logic        armed, next_armed;

  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start = scl & scl_d & sda_d & ~sda;
  wire stop  = scl & scl_d & ~sda_d & sda;

  assign bus.sda_t_o  = 1'b0;
  assign bus.sda_t_oe = sda_oe;

  always_comb begin
    logic [3:0] xd;
    xd = 4'h0;
    next_st = st;
    next_sh = sh;
    next_cnt = cnt;
    next_byte2 = byte2;
    next_rd = rd;
    next_first = first;
    next_hold = hold;
    next_switch_state = switch_state;
    next_sda_oe = sda_oe;
    next_armed = armed;
    if (start) begin
      next_st = csw_pkg::CSW_T_ADDR;
      next_cnt = 3'h0;
      next_armed = 1'b0;
      next_sda_oe = 1'b0;
    end else if (stop) begin
      next_st = csw_pkg::CSW_T_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (st)
        csw_pkg::CSW_T_IDLE, csw_pkg::CSW_T_WAIT: next_sda_oe = 1'b0;
        csw_pkg::CSW_T_ADDR: if (scl_rise) begin // [RULE1]
          next_sh = {sh[6:0], sda};
          next_cnt = cnt + 3'h1;
          next_armed = 1'b1;
        // the fall that ends the start carries no bit, so wait for one rise
        end else if (scl_fall && cnt == 3'h0 && armed) begin
          if (sh[7:1] == `CSW_DEV_ADDR) begin
            next_sda_oe = 1'b1; // [RULE2]
            next_rd = sh[0];
            next_byte2 = 1'b0;
            next_st = csw_pkg::CSW_T_AACK;
          end else next_st = csw_pkg::CSW_T_WAIT;
        end
        csw_pkg::CSW_T_AACK: if (scl_fall) begin
          if (rd) begin // [RULE9]
            next_sh = 8'h00; // [RULE10]
            next_sda_oe = 1'b1;
            next_st = csw_pkg::CSW_T_TX;
          end else begin
            next_sda_oe = 1'b0;
            next_st = csw_pkg::CSW_T_RX;
          end
        end
        csw_pkg::CSW_T_RX: if (scl_rise) begin // [RULE3]
          next_sh = {sh[6:0], sda};
          next_cnt = cnt + 3'h1;
        end else if (scl_fall && cnt == 3'h0) begin
          next_sda_oe = 1'b1;
          next_st = csw_pkg::CSW_T_RACK;
          if (!byte2) next_first = sh;
          else begin
            xd = rb_decode(first);
            if (xd[3]) // [RULE6] [RULE7] [RULE8] [RULE5]
              next_hold = switch_state[{xd[2:0], 3'h0} +: 8];
            else begin
              xd = x_decode(first[6:3]);
              if (xd[3]) // [RULE4] [RULE14]
                next_switch_state[{xd[2:0], first[2:0]}] = first[`CSW_VAL_BIT];
            end
          end
        end
        csw_pkg::CSW_T_RACK: if (scl_fall) begin
          next_sda_oe = 1'b0;
          next_st = byte2 ? csw_pkg::CSW_T_WAIT : csw_pkg::CSW_T_RX;
          next_byte2 = 1'b1;
        end
        csw_pkg::CSW_T_TX: if (scl_fall) begin
          next_cnt = cnt + 3'h1;
          next_sh = {sh[6:0], 1'b0};
          if (cnt == 3'h7) begin
            next_sda_oe = 1'b0;
            next_st = csw_pkg::CSW_T_TACK;
          end else next_sda_oe = ~next_sh[7];
        end
        csw_pkg::CSW_T_TACK: if (scl_rise) begin
          if (sda || byte2) next_st = csw_pkg::CSW_T_WAIT;
        end else if (scl_fall && !byte2) begin
          next_byte2 = 1'b1;
          next_sh = hold; // [RULE11]
          next_sda_oe = ~hold[7];
          next_st = csw_pkg::CSW_T_TX;
        end
        default: next_st = csw_pkg::CSW_T_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      st <= csw_pkg::CSW_T_IDLE;
      sh <= 8'h00;
      cnt <= 3'h0;
      byte2 <= 1'b0;
      rd <= 1'b0;
      first <= 8'h00;
      hold <= 8'h00;
      switch_state <= 64'h0;
      sda_oe <= 1'b0;
      armed <= 1'b0;
    end else begin
      scl_s <= {scl_s[0], bus.scl_i};
      sda_s <= {sda_s[0], bus.sda_i};
      scl_d <= scl;
      sda_d <= sda;
      st <= next_st;
      sh <= next_sh;
      cnt <= next_cnt;
      byte2 <= next_byte2;
      rd <= next_rd;
      first <= next_first;
      hold <= next_hold;
      switch_state <= next_switch_state;
      sda_oe <= next_sda_oe;
      armed <= next_armed;
    end
  end
endmodule

// file: design/csw_ctrl.sv
`timescale 1ns/1ps
`include "csw_map.svh"
module csw_ctrl (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // bus
  csw_if.ctrl              bus,
  // user request
  input  wire logic        req,
  input  wire logic        req_rd,
  input  wire logic [15:0] req_data,
  // user answer
  output      logic        busy,
  output      logic        done,
  output      logic        nack,
  output      logic [15:0] rd_data
);
  csw_pkg::csw_ctl_st_t st, next_st;
  logic [7:0]  div, next_div;
  logic [1:0]  ph, next_ph;
  logic [1:0]  nbyte, next_nbyte;
  logic [2:0]  cnt, next_cnt;
  logic [7:0]  sh, next_sh;
  logic [15:0] data, next_data;
  logic        rd, next_rd;
  logic        scl_l, next_scl_l;
  logic        sda_l, next_sda_l;
  logic        next_busy, next_done, next_nack;
  logic [15:0] next_rd_data;
  logic [1:0]  sda_s;

  wire tick = (div == `CSW_SCL_HALF);
  wire sda  = sda_s[1];
  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = ~scl_l;
  assign bus.sda_c_o  = 1'b0;
  assign bus.sda_c_oe = ~sda_l;

  always_comb begin
    next_st = st;
    next_div = tick ? 8'h00 : div + 8'h01;
    next_ph = ph;
    next_nbyte = nbyte;
    next_cnt = cnt;
    next_sh = sh;
    next_data = data;
    next_rd = rd;
    next_scl_l = scl_l;
    next_sda_l = sda_l;
    next_busy = busy;
    next_done = 1'b0;
    next_nack = nack;
    next_rd_data = rd_data;
    unique case (st)
      csw_pkg::CSW_C_IDLE: if (req) begin
        next_st = csw_pkg::CSW_C_START;
        next_rd = req_rd;
        next_data = req_data;
        next_sh = {`CSW_DEV_ADDR, req_rd}; // [RULE1] [RULE6] [RULE9]
        next_ph = 2'h0;
        next_busy = 1'b1;
        next_nack = 1'b0;
      end
      csw_pkg::CSW_C_START: if (tick) begin
        next_ph = ph + 2'h1;
        if (ph == 2'h0) next_sda_l = 1'b0;
        else begin
          next_scl_l = 1'b0;
          next_cnt = 3'h0;
          next_nbyte = 2'h0;
          next_ph = 2'h0;
          next_st = csw_pkg::CSW_C_BIT;
        end
      end
      csw_pkg::CSW_C_BIT, csw_pkg::CSW_C_ACK: if (tick) begin
        next_ph = ph + 2'h1;
        unique case (ph)
          2'h0: next_sda_l = (st == csw_pkg::CSW_C_ACK) ? ~(rd && nbyte != 2'h0 && nbyte != 2'h2)
                           : ((rd && nbyte != 2'h0) ? 1'b1 : sh[7]);
          2'h1: next_scl_l = 1'b1;
          2'h2: if (st == csw_pkg::CSW_C_BIT) next_sh = {sh[6:0], sda};
                else if (!(rd && nbyte != 2'h0) && sda) next_nack = 1'b1;
          default: begin
            next_scl_l = 1'b0;
            next_ph = 2'h0;
            if (st == csw_pkg::CSW_C_BIT) begin
              next_cnt = cnt + 3'h1;
              if (cnt == 3'h7) next_st = csw_pkg::CSW_C_ACK;
            end else begin
              if (rd && nbyte != 2'h0) next_rd_data = {next_rd_data[7:0], sh};
              next_nbyte = nbyte + 2'h1;
              next_sh = (nbyte == 2'h0) ? data[15:8] : data[7:0]; // [RULE3] [RULE7]
              next_st = (nbyte == 2'h2 || nack) ? csw_pkg::CSW_C_STOP : csw_pkg::CSW_C_BIT;
            end
          end
        endcase
      end
      csw_pkg::CSW_C_STOP: if (tick) begin
        next_ph = ph + 2'h1;
        unique case (ph)
          2'h0: next_sda_l = 1'b0;
          2'h1: next_scl_l = 1'b1;
          default: begin
            next_sda_l = 1'b1;
            next_st = csw_pkg::CSW_C_DONE;
          end
        endcase
      end
      default: begin
        next_st = csw_pkg::CSW_C_IDLE;
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= csw_pkg::CSW_C_IDLE;
      div <= 8'h00;
      ph <= 2'h0;
      nbyte <= 2'h0;
      cnt <= 3'h0;
      sh <= 8'h00;
      data <= 16'h0000;
      rd <= 1'b0;
      scl_l <= 1'b1;
      sda_l <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      rd_data <= 16'h0000;
      sda_s <= 2'h3;
    end else begin
      st <= next_st;
      div <= next_div;
      ph <= next_ph;
      nbyte <= next_nbyte;
      cnt <= next_cnt;
      sh <= next_sh;
      data <= next_data;
      rd <= next_rd;
      scl_l <= next_scl_l;
      sda_l <= next_sda_l;
      busy <= next_busy;
      done <= next_done;
      nack <= next_nack;
      rd_data <= next_rd_data;
      sda_s <= {sda_s[0], bus.sda_i};
    end
  end
endmodule

// file: sim/csw_props.sv
`timescale 1ns/1ps
module csw_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // bus lines
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_t_o,
  input wire logic        sda_t_oe,
  // switch array
  input wire logic [63:0] switch_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire tgt_low = sda_t_oe & ~sda_t_o;
  property p_start_clk; $fell(sda_i) && scl_i |-> ##[1:10] !scl_i; endproperty
  a_start_clk: assert property (p_start_clk) else $error("no clock after start");
  property p_tgt_steady; scl_i && $past(scl_i) |-> $stable(tgt_low); endproperty
  a_tgt_steady: assert property (p_tgt_steady) else $error("target sda moved, scl high");
  property p_tgt_pull; $rose(tgt_low) |-> !scl_i; endproperty
  a_tgt_pull: assert property (p_tgt_pull) else $error("target pulled with scl high");
  property p_scl_high; $rose(scl_i) |-> scl_i [*4]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high too short");
  property p_scl_low; $fell(scl_i) |-> !scl_i [*4]; endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl low too short");
  property p_one_sw; $changed(switch_state) |-> $onehot(switch_state ^ $past(switch_state)); endproperty
  a_one_sw: assert property (p_one_sw) else $error("more than one switch moved");
  property p_sw_low; $changed(switch_state) |-> !scl_i; endproperty
  a_sw_low: assert property (p_sw_low) else $error("switch moved with scl high");
  // no target pull in the eight cycles that follow a stop
  property p_stop_free; $rose(sda_i) && scl_i |=> !tgt_low [*8]; endproperty
  a_stop_free: assert property (p_stop_free) else $error("target pulled sda right after stop");
  c_write: cover property ($changed(switch_state));
  c_ack: cover property ($rose(tgt_low));
  c_stop: cover property ($rose(sda_i) && scl_i);
endmodule

// file: sim/crosspoint_switch_serial_access_test.sv
`timescale 1ns/1ps
`include "csw_map.svh"
module crosspoint_switch_serial_access_test;
  logic        sys_clk;
  logic        rst_b;
  logic        req;
  logic        req_rd;
  logic [15:0] req_data;
  logic        busy;
  logic        done;
  logic        nack;
  logic [15:0] rd_data;
  logic [63:0] switch_state;
  logic [63:0] model;
  int          mismatches;
  int          n_compared;
  int          cycles;
  logic [7:0]  rb_code [8] = '{`CSW_RB_X0, `CSW_RB_X1, `CSW_RB_X2, `CSW_RB_X3,
                               `CSW_RB_X4, `CSW_RB_X5, `CSW_RB_X6, `CSW_RB_X7};
  `define CSW_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); end end

  csw_if csw_if_inst ();
  csw_target csw_target_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(csw_if_inst), .switch_state(switch_state));
  csw_ctrl csw_ctrl_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(csw_if_inst), .req(req), .req_rd(req_rd),
    .req_data(req_data), .busy(busy), .done(done), .nack(nack), .rd_data(rd_data));
  csw_props csw_props_inst (.sys_clk(sys_clk), .rst_b(rst_b), .scl_i(csw_if_inst.scl_i), .sda_i(csw_if_inst.sda_i),
    .sda_t_o(csw_if_inst.sda_t_o), .sda_t_oe(csw_if_inst.sda_t_oe), .switch_state(switch_state));

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one whole transaction, waits for the done pulse
  task automatic xfer(input logic rd, input logic [15:0] data);
    int n;
    @(negedge sys_clk);
    req = 1'b1;
    req_rd = rd;
    req_data = data;
    @(negedge sys_clk);
    req = 1'b0;
    `CSW_CHK(busy, 1'b1)
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    `CSW_CHK(done, 1'b1)
    `CSW_CHK(busy, 1'b0)
  endtask

  task automatic sw_write(input int x, input int y, input logic v);
    logic [3:0] xc;
    xc = (x < 6) ? 4'(x) : 4'(x + 2);
    xfer(1'b0, {v, xc, 3'(y), 8'h00});
    model[8*x+y] = v;
    `CSW_CHK(nack, 1'b0)
    `CSW_CHK(switch_state, model)
  endtask

  task automatic read_x(input int x);
    xfer(1'b0, {rb_code[x], 8'ha5});
    `CSW_CHK(switch_state, model)
    xfer(1'b1, 16'h0000);
    `CSW_CHK(nack, 1'b0)
    `CSW_CHK(rd_data[15:8], 8'h00)
    `CSW_CHK(rd_data[7:0], model[8*x +: 8])
  endtask

  task automatic t_lines();
    for (int x = 0; x < 8; x++) begin
      sw_write(x, 7 - x, 1'b1);
      sw_write(x, x, 1'b1);
    end
    for (int x = 0; x < 8; x++) begin
      read_x(x);
    end
  endtask

  // clear one switch, neighbour on same line must stay closed
  task automatic t_clear();
    sw_write(2, 5, 1'b0);
    read_x(2);
    `CSW_CHK(rd_data[7:0], 8'h04)
  endtask

  task automatic t_reserved();
    logic [3:0] codes [8] = '{4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, {1'b1, codes[i], 3'h5, 8'h00});
      `CSW_CHK(switch_state, model)
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ceiling well above the roughly 25000 cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    rst_b = 1'b0;
    req = 1'b0;
    req_rd = 1'b0;
    req_data = 16'h0000;
    model = 64'h0;
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    t_lines();
    t_clear();
    t_reserved();
    results();
  end
endmodule
